// File: hw/ucl_consts.svh
// register offsets, field positions and timing constants for the uart channel block
`ifndef UCL_CONSTS_SVH
`define UCL_CONSTS_SVH
`define UCL_ADR_RX_MODE     4'h0
`define UCL_ADR_TX_DIV      4'h1
`define UCL_ADR_RX_DIV      4'h2
`define UCL_ADR_INVERT      4'h3
`define UCL_ADR_OUT_LVL     4'h4
`define UCL_ADR_OUT_EN      4'h5
`define UCL_ADR_FILT_EN     4'h6
`define UCL_ADR_CLR_TRIG    4'h7
`define UCL_ADR_TX_DATA     4'h8
`define UCL_ADR_RX_STATUS   4'h9
`define UCL_ADR_RX_DATA     4'ha
`define UCL_ADR_CONTROL     4'hb
`define UCL_DIV_HI          15
`define UCL_DIV_LO          9
`define UCL_SLC_HI          5
`define UCL_SLC_LO          4
`define UCL_PTC_HI          9
`define UCL_PTC_LO          8
`define UCL_DLS_HI          1
`define UCL_DLS_LO          0
`define UCL_RXE_BIT         14
`define UCL_FE_BIT          2
`define UCL_PE_BIT          1
`define UCL_OV_BIT          0
`define UCL_RX_MODE_RST     16'h0087
`define UCL_DIV_RST         16'h9a00
`define UCL_RX_SETUP_CYC    3'd4
`endif

// File: hw/ucl_pkg.sv
// types shared by the uart channel block
package ucl_pkg;
  typedef enum logic [1:0] {UCL_IDLE, UCL_START, UCL_BITS, UCL_STOP} ucl_phase_e;
  typedef logic [8:0] ucl_word_t;

  function automatic logic [3:0] ucl_word_bits(input logic [1:0] code);
    case (code)
      2'b01:   ucl_word_bits = 4'd9;
      2'b10:   ucl_word_bits = 4'd7;
      default: ucl_word_bits = 4'd8;
    endcase
  endfunction

  function automatic logic [7:0] ucl_half_div(input logic [6:0] n);
    ucl_half_div = {1'b0, n};
  endfunction
endpackage

// File: hw/ucl_stream_if.sv
// valid/ready word channel between the block's modules
interface ucl_stream_if;
  logic                  valid;
  logic                  ready;
  ucl_pkg::ucl_word_t    data;
  modport src (output valid, output data, input ready);
  modport dst (input valid, input data, output ready);
endinterface

// File: hw/ucl_skid_buf.sv
// two-entry buffer in the transmit word path
module ucl_skid_buf #(
  parameter int DEPTH = 2
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  ucl_stream_if.dst in_s,
  ucl_stream_if.src out_s
);
  import ucl_pkg::*;
  ucl_word_t       mem [DEPTH];
  logic [0:0]      wr_ptr;
  logic [0:0]      rd_ptr;
  logic [1:0]      count;
  logic            push;
  logic            pop;

  assign in_s.ready  = (count != 2'(DEPTH));
  assign out_s.valid = (count != 2'd0);
  assign out_s.data  = mem[rd_ptr];
  assign push        = in_s.valid && in_s.ready;
  assign pop         = out_s.valid && out_s.ready;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_s.data;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'd0;
    end else begin
      if (push) begin
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      count <= count + 2'(push) - 2'(pop);
    end
  end
endmodule

// File: hw/ucl_tx_engine.sv
// transmit serialiser: start, data, parity, stop bits at divided bit rate
module ucl_tx_engine (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [6:0] div_i,
  input  wire logic [1:0] stop_code_i,
  input  wire logic [1:0] par_code_i,
  input  wire logic [1:0] len_code_i,
  ucl_stream_if.dst       word_s,
  output logic            line_o,
  output logic            busy_o
);
  import ucl_pkg::*;
  ucl_phase_e  phase;
  logic [7:0]  half_cnt;
  logic        half_tgl;
  logic        bit_tick;
  logic [9:0]  shreg;
  logic [3:0]  bits_left;
  logic [1:0]  stops_left;
  logic [3:0]  nbits;
  logic        par;
  logic [9:0]  load;

  assign nbits        = ucl_word_bits(len_code_i);
  assign word_s.ready = (phase == UCL_IDLE);
  assign busy_o       = (phase != UCL_IDLE);

  // one bit lasts 2*(N+1) clocks: two half periods of N+1
  always_ff @(posedge clk_i) begin
    if (rst_i || phase == UCL_IDLE) begin
      half_cnt <= 8'd0;
      half_tgl <= 1'b0;
    end else if (half_cnt == ucl_half_div(div_i)) begin
      half_cnt <= 8'd0;
      half_tgl <= ~half_tgl;
    end else begin
      half_cnt <= half_cnt + 8'd1;
    end
  end
  assign bit_tick = half_tgl && (half_cnt == ucl_half_div(div_i));

  always_comb begin
    par = ^(word_s.data & ((9'h1 << nbits) - 9'h1));
    if (par_code_i == 2'b11) begin
      par = ~par;
    end else if (par_code_i == 2'b01) begin
      par = 1'b0;
    end
  end

  // parity goes right after the last data bit, whatever the word length
  assign load = {1'b0, word_s.data & ((9'h1 << nbits) - 9'h1)} | (10'(par) << nbits);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase      <= UCL_IDLE;
      line_o     <= 1'b1;
      shreg      <= 10'h3ff;
      bits_left  <= 4'd0;
      stops_left <= 2'd0;
    end else begin
      case (phase)
        UCL_IDLE: begin
          line_o <= 1'b1;
          if (word_s.valid) begin
            phase      <= UCL_START;
            line_o     <= 1'b0;
            shreg      <= load;
            bits_left  <= nbits + ((par_code_i != 2'b00) ? 4'd1 : 4'd0);
            stops_left <= stop_code_i;
          end
        end
        UCL_START, UCL_BITS: begin
          if (bit_tick) begin
            if (bits_left != 4'd0) begin
              phase     <= UCL_BITS;
              line_o    <= shreg[0];
              bits_left <= bits_left - 4'd1;
              shreg     <= (nbits == 4'd9 || bits_left != 4'd2) ? {1'b1, shreg[9:1]}
                           : {1'b1, shreg[9:1]} ;
            end else begin
              phase  <= (stops_left == 2'd0) ? UCL_IDLE : UCL_STOP;
              line_o <= 1'b1;
            end
          end
        end
        UCL_STOP: begin
          if (bit_tick) begin
            stops_left <= stops_left - 2'd1;
            if (stops_left == 2'd1) begin
              phase <= UCL_IDLE;
            end
          end
        end
        default: phase <= UCL_IDLE;
      endcase
    end
  end
endmodule

// File: hw/ucl_channel.sv
// uart channel pair: configuration registers, line control, receiver, wishbone slave
//
// Our own choices: the Wishbone register port and the register addresses.
`include "ucl_consts.svh"

module ucl_channel
  import ucl_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [5:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  output logic             err_o,
  input  wire logic        receive_pin_i,
  output logic             txd_o,
  output logic             txd_oe_o
);
  logic [15:0]   rx_mode_setup_reg;
  logic [15:0]   tx_divider_reg;
  logic [15:0]   rx_divider_reg;
  logic          tx_level_invert;
  logic          tx_idle_level;
  logic          tx_output_enable;
  logic          rx_noise_filter_on;
  logic          rx_start_trigger;
  logic [2:0]    err_flags;
  ucl_word_t     rx_word;
  logic          rx_full;
  logic          hit;
  logic [3:0]    widx;
  logic          wr;
  logic          rd_word;
  logic          tx_busy;
  logic          tx_line;
  logic          tx_push;
  logic [2:0]    clr_req;
  logic [2:0]    err_set;
  logic [2:0]    setup_cnt;

  ucl_stream_if  tx_in();
  ucl_stream_if  tx_out();

  // registers sit at word addresses; sel must cover the low half for the 16-bit data
  assign widx    = adr_i[5:2];
  assign hit     = cyc_i && stb_i && !ack_o && !err_o;
  assign wr      = hit && we_i && (widx <= `UCL_ADR_CONTROL) && sel_i[0] && sel_i[1];
  assign rd_word = hit && !we_i && (widx == `UCL_ADR_RX_DATA);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
    end else begin
      ack_o <= hit && (widx <= `UCL_ADR_CONTROL);
      err_o <= hit && (widx > `UCL_ADR_CONTROL);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_mode_setup_reg  <= `UCL_RX_MODE_RST;
      tx_divider_reg     <= `UCL_DIV_RST;
      rx_divider_reg     <= `UCL_DIV_RST;
      tx_level_invert    <= 1'b0;
      tx_idle_level      <= 1'b1;
      tx_output_enable   <= 1'b0;
      rx_noise_filter_on <= 1'b0;
    end else if (wr) begin
      case (widx)
        `UCL_ADR_RX_MODE:  rx_mode_setup_reg  <= dat_i[15:0];
        `UCL_ADR_TX_DIV:   tx_divider_reg     <= dat_i[15:0];
        `UCL_ADR_RX_DIV:   rx_divider_reg     <= dat_i[15:0];
        `UCL_ADR_INVERT:   tx_level_invert    <= dat_i[0];
        `UCL_ADR_OUT_LVL:  tx_idle_level      <= dat_i[0];
        `UCL_ADR_OUT_EN:   tx_output_enable   <= dat_i[0];
        `UCL_ADR_FILT_EN:  rx_noise_filter_on <= dat_i[0];
        default: ;
      endcase
    end
  end

  // start trigger: a write of 1 to the control word; cleared with receive enable
  always_ff @(posedge clk_i) begin
    if (rst_i || !rx_mode_setup_reg[`UCL_RXE_BIT]) begin
      rx_start_trigger <= 1'b0;
      setup_cnt        <= 3'd0;
    end else begin
      if (setup_cnt != `UCL_RX_SETUP_CYC) begin
        setup_cnt <= setup_cnt + 3'd1;
      end
      // a trigger before the receive path has settled is ignored
      if (wr && widx == `UCL_ADR_CONTROL && dat_i[0] && setup_cnt == `UCL_RX_SETUP_CYC) begin
        rx_start_trigger <= 1'b1;
      end else if (wr && widx == `UCL_ADR_CONTROL && dat_i[1]) begin
        rx_start_trigger <= 1'b0;
      end
    end
  end

  always_comb begin
    dat_o = 32'h0;
    case (widx)
      `UCL_ADR_RX_MODE:   dat_o[15:0] = rx_mode_setup_reg;
      `UCL_ADR_TX_DIV:    dat_o[15:0] = tx_divider_reg;
      `UCL_ADR_RX_DIV:    dat_o[15:0] = rx_divider_reg;
      `UCL_ADR_INVERT:    dat_o[0]    = tx_level_invert;
      `UCL_ADR_OUT_LVL:   dat_o[0]    = tx_idle_level;
      `UCL_ADR_OUT_EN:    dat_o[0]    = tx_output_enable;
      `UCL_ADR_FILT_EN:   dat_o[0]    = rx_noise_filter_on;
      `UCL_ADR_TX_DATA:   dat_o[0]    = tx_busy;
      `UCL_ADR_RX_STATUS: dat_o[3:0]  = {rx_full, err_flags};
      `UCL_ADR_RX_DATA:   dat_o[8:0]  = rx_word;
      `UCL_ADR_CONTROL:   dat_o[0]    = rx_start_trigger;
      default:            dat_o       = 32'h0; // clear triggers read as zero
    endcase
  end

  // transmit path: writes to the data word enter the two-entry buffer
  assign tx_push     = wr && (widx == `UCL_ADR_TX_DATA);
  assign tx_in.valid = tx_push;
  assign tx_in.data  = dat_i[8:0];

  ucl_skid_buf #(
    .DEPTH (2)
  ) u_buf (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .in_s  (tx_in),
    .out_s (tx_out)
  );

  ucl_tx_engine u_tx (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .div_i       (tx_divider_reg[`UCL_DIV_HI:`UCL_DIV_LO]),
    .stop_code_i (rx_mode_setup_reg[`UCL_SLC_HI:`UCL_SLC_LO]),
    .par_code_i  (rx_mode_setup_reg[`UCL_PTC_HI:`UCL_PTC_LO]),
    .len_code_i  (rx_mode_setup_reg[`UCL_DLS_HI:`UCL_DLS_LO]),
    .word_s      (tx_out),
    .line_o      (tx_line),
    .busy_o      (tx_busy)
  );

  // output: frame line xor tx_level_invert while a frame runs with enable on, else the idle level, never inverted
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      txd_o    <= 1'b1;
      txd_oe_o <= 1'b0;
    end else begin
      txd_oe_o <= tx_output_enable;
      if (tx_busy && tx_output_enable) begin
        txd_o <= tx_line ^ tx_level_invert;
      end else begin
        txd_o <= tx_idle_level;
      end
    end
  end

  // receive pin: three-stage synchroniser then optional filter that holds until two successive samples agree
  logic [2:0] rx_sync;
  logic       rx_stable;
  logic       rx_filt;
  logic       rx_in;
  logic       rx_in_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_sync   <= 3'b111;
      rx_stable <= 1'b1;
      rx_filt   <= 1'b1;
    end else begin
      rx_sync <= {rx_sync[1:0], receive_pin_i};
      if (rx_sync[1] == rx_sync[2]) begin
        rx_stable <= rx_sync[2];
      end
      rx_filt <= rx_stable;
    end
  end
  // filter needs the level to hold one extra clock before it counts
  assign rx_in = rx_noise_filter_on ? ((rx_stable == rx_filt) ? rx_filt : rx_in_q)
                                    : rx_stable;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_in_q <= 1'b1;
    end else begin
      rx_in_q <= rx_in;
    end
  end

  // receiver: samples mid-bit at the rx divider rate
  ucl_phase_e  rx_phase;
  logic [8:0]  rx_cnt;
  logic [8:0]  rx_period;
  logic [3:0]  rx_left;
  logic [9:0]  rx_shift;
  logic [3:0]  rx_nbits;
  logic        rx_par_on;
  logic        rx_samp;
  logic [1:0]  rx_code_par;

  assign rx_code_par = rx_mode_setup_reg[`UCL_PTC_HI:`UCL_PTC_LO];
  assign rx_par_on   = (rx_code_par != 2'b00);
  assign rx_nbits    = ucl_word_bits(rx_mode_setup_reg[`UCL_DLS_HI:`UCL_DLS_LO]);
  assign rx_period   = {ucl_half_div(rx_divider_reg[`UCL_DIV_HI:`UCL_DIV_LO]), 1'b1};
  assign rx_samp     = (rx_cnt == rx_period);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_phase <= UCL_IDLE;
      rx_cnt   <= 9'd0;
      rx_left  <= 4'd0;
      rx_shift <= 10'h0;
      err_set  <= 3'b000;
      rx_word  <= 9'h0;
      rx_full  <= 1'b0;
    end else begin
      err_set <= 3'b000;
      if (rd_word) begin
        rx_full <= 1'b0;
      end
      case (rx_phase)
        UCL_IDLE: begin
          if (rx_start_trigger && !rx_in) begin
            rx_phase <= UCL_START;
            rx_cnt   <= {1'b0, rx_period[8:1]};
          end
        end
        UCL_START: begin
          rx_cnt <= rx_samp ? 9'd0 : rx_cnt + 9'd1;
          if (rx_samp) begin
            rx_phase <= rx_in ? UCL_IDLE : UCL_BITS;
            rx_left  <= rx_nbits + (rx_par_on ? 4'd1 : 4'd0);
            rx_shift <= 10'h0;
          end
        end
        UCL_BITS: begin
          rx_cnt <= rx_samp ? 9'd0 : rx_cnt + 9'd1;
          if (rx_samp) begin
            rx_shift <= {rx_in, rx_shift[9:1]};
            rx_left  <= rx_left - 4'd1;
            if (rx_left == 4'd1) begin
              rx_phase <= UCL_STOP;
            end
          end
        end
        UCL_STOP: begin
          rx_cnt <= rx_samp ? 9'd0 : rx_cnt + 9'd1;
          if (rx_samp || rx_mode_setup_reg[`UCL_SLC_HI:`UCL_SLC_LO] == 2'b00) begin
            rx_phase <= UCL_IDLE;
            rx_word  <= 9'(rx_shift >> (4'd10 - rx_left_total(rx_nbits, rx_par_on)));
            rx_full  <= 1'b1;
            err_set[`UCL_OV_BIT] <= rx_full && !rd_word;
            err_set[`UCL_FE_BIT] <= rx_samp && !rx_in;
            err_set[`UCL_PE_BIT] <= rx_code_par[1] && (^rx_shift ^ rx_code_par[0]);
          end
        end
        default: rx_phase <= UCL_IDLE;
      endcase
    end
  end

  function automatic logic [3:0] rx_left_total(input logic [3:0] nb, input logic pon);
    rx_left_total = nb + (pon ? 4'd1 : 4'd0);
  endfunction

  // error flags: a new error in the clearing cycle wins over the clear
  assign clr_req = (wr && widx == `UCL_ADR_CLR_TRIG) ? dat_i[2:0] : 3'b000;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      err_flags <= 3'b000;
    end else begin
      err_flags <= (err_flags & ~clr_req) | err_set;
    end
  end
endmodule

// File: verification/ucl_channel_monitor.sv
// concurrent checks on the uart channel block's bus and line ports
module ucl_channel_monitor (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [5:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        err_o,
  input wire logic        receive_pin_i,
  input wire logic        txd_o,
  input wire logic        txd_oe_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic       take;
  logic       en_wr;
  logic [2:0] since_en;
  assign take = cyc_i && stb_i && !ack_o && !err_o;
  // age of the last enable write, so a change of the enable pin can be traced to it
  always_ff @(posedge clk_i) begin
    if (rst_i || (take && we_i && adr_i[5:2] == 4'h5)) since_en <= 3'h0;
    else if (since_en != 3'h7) since_en <= since_en + 3'h1;
  end
  always_ff @(posedge clk_i) begin
    if (take && we_i && adr_i[5:2] == 4'h5) en_wr <= dat_i[0];
  end
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  a_mapped_ack: assert property (take && adr_i[5:2] <= 4'hb |=> ack_o && !err_o)
    else $error("mapped access not acknowledged next cycle");
  a_unmapped_err: assert property (take && adr_i[5:2] > 4'hb |=> err_o && !ack_o)
    else $error("unmapped access not refused next cycle");
  a_read_upper: assert property (ack_o && !we_i |-> dat_o[31:16] == 16'h0)
    else $error("read data upper half not zero");
  a_clr_reads_zero: assert property (ack_o && !we_i && adr_i[5:2] == 4'h7 |-> dat_o == 32'h0)
    else $error("clear trigger register reads nonzero");
  a_oe_follows: assert property (take && we_i && sel_i[1:0] == 2'h3 && adr_i[5:2] == 4'h5
    |-> ##[1:2] txd_oe_o == en_wr)
    else $error("output enable does not follow its register");
  a_oe_only_written: assert property ($changed(txd_oe_o) |-> since_en <= 3'h3)
    else $error("output enable changed without a write");
  a_reset_idle: assert property (disable iff (1'b0) rst_i |=> txd_o && !txd_oe_o)
    else $error("line not idle high and released after reset");
endmodule

bind ucl_channel ucl_channel_monitor mon (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .err_o(err_o), .receive_pin_i(receive_pin_i), .txd_o(txd_o), .txd_oe_o(txd_oe_o)
);

// File: verification/ucl_remote_dev.sv
// remote serial device: sends frames to the receiver, times runs on the transmit line
module ucl_remote_dev (
  input  wire logic clk_i,
  input  wire logic line_i,
  output logic      line_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial line_o = 1'b1;
  // a bad stop level is how the bench provokes a framing error
  task automatic send(input logic [9:0] bits, input int nb, input logic stop_lvl, input int p);
    int i;
    line_o <= 1'b0;
    repeat (p) @(posedge clk_i);
    for (i = 0; i < nb; i++) begin
      line_o <= bits[i];
      repeat (p) @(posedge clk_i);
    end
    line_o <= stop_lvl;
    repeat (p) @(posedge clk_i);
    line_o <= 1'b1;
    repeat (3 * p) @(posedge clk_i);
  endtask
  task automatic run_len(input logic lvl, output int n);
    n = 0;
    while (line_i === lvl && n < 4000) begin
      n++;
      @(posedge clk_i);
    end
  endtask
endmodule

// File: verification/tb.sv
// self-checking bench for the uart channel block
`include "ucl_consts.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [6:0] div; logic [1:0] len; logic [1:0] stop; logic [8:0] word; int tail;} ucl_row_s;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [5:0]  adr = 6'h00;
  logic [3:0]  sel = 4'hf;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  logic        err;
  logic        rxd;
  logic        txd;
  logic        txd_oe;
  logic [31:0] q;
  logic        e;
  int          n;
  int          p;
  int          err_count = 0;
  int          check_count = 0;
  // tail = high periods after the last low data bit: set data bits plus stop bits
  ucl_row_s rows [6] = '{'{7'h4d, 2'h3, 2'h1, 9'h0c1, 3}, '{7'h03, 2'h3, 2'h2, 9'h0c1, 4},
    '{7'h00, 2'h3, 2'h0, 9'h0c1, 2}, '{7'h7f, 2'h2, 2'h1, 9'h041, 2},
    '{7'h03, 2'h1, 2'h1, 9'h1c1, 4}, '{7'h03, 2'h3, 2'h3, 9'h0c1, 5}};
  logic [15:0] rst_val [8] = '{16'h0087, 16'h9a00, 16'h9a00, 16'h0, 16'h1, 16'h0, 16'h0, 16'h0};
  always #5 clk = ~clk;
  ucl_channel DUT (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .err_o(err),
    .receive_pin_i(rxd), .txd_o(txd), .txd_oe_o(txd_oe));
  ucl_remote_dev rem (.clk_i(clk), .line_i(txd), .line_o(rxd));
  task automatic results;
    if (err_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] idx, input logic [15:0] d,
                    input logic [3:0] s = 4'hf);
    int k;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'h0};
    sel <= s;
    wdat <= {16'h0, d};
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && err !== 1'b1 && k < 50);
    if (k >= 50) err_count++;
    q = rdat;
    e = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_low;
    int k;
    k = 0;
    while (txd !== 1'b0 && k < 20000) begin
      @(posedge clk);
      k++;
    end
    if (k >= 20000) err_count++;
  endtask
  // polls the busy bit; it shows only the engine phase, and the second frame is already under way when this runs
  task automatic drain;
    int k;
    k = 0;
    q = 32'h1;
    while (q[0] !== 1'b0 && k < 2000) begin
      wb(0, `UCL_ADR_TX_DATA, 16'h0);
      k++;
    end
    if (k >= 2000) err_count++;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    results();
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    wb(1, `UCL_ADR_OUT_EN, 16'h1);
    chk("output enable on", 1, txd_oe);
    foreach (rows[i]) begin
      p = 2 * (rows[i].div + 1);
      wb(1, `UCL_ADR_TX_DIV, {rows[i].div, 9'h000});
      wb(1, `UCL_ADR_RX_MODE, {10'h000, rows[i].stop, 2'h0, rows[i].len});
      fork
        begin
          wb(1, `UCL_ADR_TX_DATA, {7'h00, rows[i].word});
          wb(1, `UCL_ADR_TX_DATA, {7'h00, rows[i].word});
        end
        begin
          wait_low();
          rem.run_len(0, n); chk("start bit", p, n);
          rem.run_len(1, n); chk("first data bit", p, n);
          rem.run_len(0, n); chk("low data bits", 5 * p, n);
          // the engine spends one idle clock at the line level before the buffered word
          rem.run_len(1, n); chk("tail and stop bits", rows[i].tail * p + 1, n);
          rem.run_len(0, n); chk("next start bit", p, n);
        end
      join
      drain();
    end
    rst <= 1'b1;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    chk("idle after reset", 1, txd);
    for (int i = 0; i < 8; i++) begin
      wb(0, i[3:0], 16'h0);
      chk("reset value", {16'h0, rst_val[i]}, q);
    end
    wb(1, `UCL_ADR_OUT_EN, 16'h1);
    wb(1, `UCL_ADR_TX_DIV, {7'h03, 9'h000});
    wb(1, `UCL_ADR_RX_MODE, 16'h0013);
    wb(1, `UCL_ADR_INVERT, 16'h1);
    fork
      wb(1, `UCL_ADR_TX_DATA, 16'h00c1);
      begin
        wait_low();
        rem.run_len(0, n); chk("inverted first bit", 8, n);
        rem.run_len(1, n); chk("inverted low bits", 40, n);
        rem.run_len(0, n); chk("inverted tail", 24, n);
      end
    join
    drain();
    chk("idle not inverted", 1, txd);
    wb(1, `UCL_ADR_INVERT, 16'h0);
    wb(1, `UCL_ADR_INVERT, 16'h1, 4'h0);
    wb(0, `UCL_ADR_INVERT, 16'h0);
    chk("write without byte selects", 0, q);
    wb(1, `UCL_ADR_OUT_LVL, 16'h0);
    wb(0, `UCL_ADR_OUT_LVL, 16'h0);
    chk("idle level low", 0, txd);
    wb(1, `UCL_ADR_OUT_LVL, 16'h1);
    wb(1, `UCL_ADR_OUT_EN, 16'h0);
    wb(1, `UCL_ADR_TX_DATA, 16'h0000);
    repeat (40) @(posedge clk);
    chk("disabled enable", 0, txd_oe);
    chk("disabled line", 1, txd);
    drain();
    wb(0, 4'hc, 16'h0);
    chk("unmapped refusal", 1, e);
    wb(1, `UCL_ADR_RX_DIV, {7'h03, 9'h000});
    wb(1, `UCL_ADR_FILT_EN, 16'h1);
    wb(0, `UCL_ADR_FILT_EN, 16'h0);
    chk("filter enable", 1, q);
    wb(1, `UCL_ADR_RX_MODE, 16'h4213);
    repeat (4) @(posedge clk);
    wb(1, `UCL_ADR_CONTROL, 16'h1);
    rem.send(10'h055, 9, 1'b1, 8);
    wb(0, `UCL_ADR_RX_STATUS, 16'h0);
    chk("clean receive status", 8, q & 32'hf);
    wb(0, `UCL_ADR_RX_DATA, 16'h0);
    chk("received word", 32'h55, q);
    rem.send(10'h055, 9, 1'b0, 8);
    rem.send(10'h155, 9, 1'b1, 8);
    rem.send(10'h055, 9, 1'b1, 8);
    wb(0, `UCL_ADR_RX_STATUS, 16'h0);
    chk("error flags set", 7, q & 32'h7);
    wb(1, `UCL_ADR_CLR_TRIG, 16'h0);
    wb(0, `UCL_ADR_RX_STATUS, 16'h0);
    chk("zero triggers keep flags", 7, q & 32'h7);
    wb(1, `UCL_ADR_CLR_TRIG, 16'h4);
    wb(0, `UCL_ADR_RX_STATUS, 16'h0);
    chk("framing flag cleared", 3, q & 32'h7);
    wb(1, `UCL_ADR_CLR_TRIG, 16'h3);
    wb(0, `UCL_ADR_RX_STATUS, 16'h0);
    chk("all flags cleared", 0, q & 32'h7);
    wb(0, `UCL_ADR_CLR_TRIG, 16'h0);
    chk("trigger register reads zero", 0, q);
    results();
  end
endmodule
